// File: rtl/event_counter_pkg.sv
// constants and types shared by the event counter bank
package event_counter_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_CNT = 4;
   localparam int CNT_W   = 32;
   localparam int NUM_EVT = 12;
   localparam int NUM_IO  = 4;
   localparam int NUM_TMR = 4;
   localparam int NUM_ACT = 4;
   localparam int NUM_SRC = 1 + NUM_EVT + NUM_IO + NUM_CNT + NUM_TMR + 1
                            + NUM_ACT;
   localparam int IDX_W   = 2;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_SELECT     = 8'h00;
   localparam logic [7:0] ADDR_CONFIG     = 8'h04;
   localparam logic [7:0] ADDR_TERM       = 8'h08;
   localparam logic [7:0] ADDR_VALUE      = 8'h0C;
   localparam logic [7:0] ADDR_LATCHED    = 8'h10;
   localparam logic [7:0] ADDR_CONTROL    = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CFG_SRC_LSB  = 0;
   localparam int CFG_EDGE_LSB = 8;
   localparam int CTL_CLEAR    = 0;
   localparam int CTL_ACTIVE   = 0;

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      src_off      = 5'h00,
      src_acq_trig = 5'h01,
      src_io0      = 5'h0D,
      src_cnt_end0 = 5'h11,
      src_timer0   = 5'h15,
      src_tick     = 5'h19,
      src_action0  = 5'h1A
   } src_t;

   typedef enum logic [1:0] {
      edge_up   = 2'h0,
      edge_down = 2'h1,
      edge_both = 2'h2
   } edge_t;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0]   RST_TERM  = 32'h0000_0000;
   localparam logic [CNT_W-1:0]   RST_VALUE = 32'h0000_0000;
   localparam logic [NUM_CNT-1:0] RST_MASK  = 4'h0;
   localparam logic [IDX_W-1:0]   RST_INDEX = 2'h0;

endpackage

// File: rtl/cnt_ctrl_if.sv
// carrier between the register front end and one counter cell
`timescale 1ns/1ns
interface cnt_ctrl_if;
   import event_counter_pkg::*;
   src_t             src;
   edge_t            edge_sel;
   logic             src_level;
   logic [CNT_W-1:0] term;
   logic             wr_value;
   logic [CNT_W-1:0] wr_data;
   logic             clear;
   logic [CNT_W-1:0] value;
   logic [CNT_W-1:0] latched;
   logic             active;
   logic             done;

   modport ctrl (
      output src, edge_sel, src_level, term, wr_value, wr_data, clear,
      input  value, latched, active, done
   );
   modport cnt (
      input  src, edge_sel, src_level, term, wr_value, wr_data, clear,
      output value, latched, active, done
   );
endinterface

// File: rtl/event_counter_cell.sv
// one counter: edge qualification, count, stop at terminal, clear latch
`timescale 1ns/1ns
module event_counter_cell
   import event_counter_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset_n,
   cnt_ctrl_if.cnt   bus
);

   logic             prev_ff;
   logic [CNT_W-1:0] value_ff;
   logic [CNT_W-1:0] latched_ff;
   logic             active_ff;
   logic             done_ff;
   logic             hit;
   logic [CNT_W-1:0] nxt_value;

   // ------------------------------------------------------------
   // edge qualification
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= bus.src_level;
      end
   end

   always_comb begin
      hit = 1'b0;
      case (bus.edge_sel)
         edge_up:   hit = bus.src_level & ~prev_ff;
         edge_down: hit = ~bus.src_level & prev_ff;
         edge_both: hit = bus.src_level ^ prev_ff;
         default:   hit = 1'b0;
      endcase
      if (bus.src == src_off) begin
         hit = 1'b0;
      end
   end

   assign nxt_value = value_ff + 32'h0000_0001;

   // ------------------------------------------------------------
   // value, priority clear over write over count
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         value_ff   <= RST_VALUE;
         latched_ff <= RST_VALUE;
         active_ff  <= 1'b1;
         done_ff    <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (bus.clear) begin
            latched_ff <= value_ff;
            value_ff   <= RST_VALUE;
            active_ff  <= 1'b1;
         end else if (bus.wr_value) begin
            value_ff <= bus.wr_data;
         end else if (hit && active_ff) begin
            value_ff <= nxt_value;
            // zero terminal means free running with wrap
            if (bus.term != RST_TERM && nxt_value == bus.term) begin
               done_ff   <= 1'b1;
               active_ff <= 1'b0;
            end
         end
      end
   end

   assign bus.value   = value_ff;
   assign bus.latched = latched_ff;
   assign bus.active  = active_ff;
   assign bus.done    = done_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_clear_latch;
      bus.clear |=> (latched_ff == $past(value_ff)) && (value_ff == 0);
   endproperty
   a_clear_latch: assert property (p_clear_latch)
      else $error("clear did not latch previous value");

   property p_clear_resume;
      bus.clear |=> active_ff;
   endproperty
   a_clear_resume: assert property (p_clear_resume)
      else $error("counter not active after clear");

   property p_off_hold;
      (bus.src == src_off && !bus.clear && !bus.wr_value)
         |=> value_ff == $past(value_ff);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("counter moved with source off");

   property p_one_count;
      (hit && active_ff && !bus.clear && !bus.wr_value)
         |=> value_ff == $past(value_ff) + 32'h0000_0001;
   endproperty
   a_one_count: assert property (p_one_count)
      else $error("qualifying edge did not add exactly one");

   property p_done_stop;
      done_ff |-> !active_ff && value_ff == bus.term;
   endproperty
   a_done_stop: assert property (p_done_stop)
      else $error("done without stop at terminal count");

   property p_stopped_hold;
      (!active_ff && !bus.clear && !bus.wr_value) [*2]
         |-> value_ff == $past(value_ff);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold)
      else $error("stopped counter kept counting");

   property p_down_only;
      (bus.edge_sel == edge_down && bus.src_level && !prev_ff) |-> !hit;
   endproperty
   a_down_only: assert property (p_down_only)
      else $error("falling mode counted a rising edge");

   property p_write;
      (bus.wr_value && !bus.clear) |=> value_ff == $past(bus.wr_data);
   endproperty
   a_write: assert property (p_write)
      else $error("value write not taken");

   c_done:  cover property (done_ff);
   c_clear: cover property (bus.clear && value_ff != 0);
   c_both:  cover property (bus.edge_sel == edge_both && hit && !prev_ff);

endmodule

// File: rtl/event_counter_bank.sv
// wishbone front end, source routing and interrupts of the counter bank
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
//
// Overview of operation
// - several counters, config goes to selected index
// - counts only its source; off holds value
// - acquisition and frame events add one each
// - line and exposure timing events add one
// - I/O line transitions counted with edge qualifier
// - counter end usable as source for cascading
// - timer end pulse adds one
// - time base tick adds one, acts as timer
// - broadcast action assertion adds one
// - edge choice rising, falling or both
// - value reset, read or written any time
// - event raised when terminal count reached
// - clear latches value held just before reset
// - terminal count gives done, inactive, stop
// - soft clear resets and resumes counting
module event_counter_bank
   import event_counter_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [NUM_EVT-1:0] acq_event_in,
   input  wire logic [NUM_IO-1:0]  io_line_in,
   input  wire logic [NUM_TMR-1:0] timer_done_pulse,
   input  wire logic               time_base_tick,
   input  wire logic [NUM_ACT-1:0] action_in,
   output logic      [NUM_CNT-1:0] count_done_event,
   output logic      [NUM_CNT-1:0] counting_indication,
   output logic                    irq
);

   // ------------------------------------------------------------
   // byte lane merge
   // ------------------------------------------------------------
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [IDX_W-1:0]   index_ff;
   src_t               src_ff      [NUM_CNT];
   edge_t              edge_ff     [NUM_CNT];
   logic [CNT_W-1:0]   term_ff     [NUM_CNT];
   logic [NUM_CNT-1:0] irq_status_ff;
   logic [NUM_CNT-1:0] irq_mask_ff;
   logic               ack_ff;
   logic [31:0]        rdata_ff;
   logic [NUM_IO-1:0]  io_s1_ff;
   logic [NUM_IO-1:0]  io_s2_ff;
   logic [NUM_IO-1:0]  io_s3_ff;
   logic [NUM_IO-1:0]  io_filt_ff;

   logic               bus_req;
   logic               wr_stb;
   logic [NUM_CNT-1:0] cnt_done;
   logic [NUM_CNT-1:0] cnt_active;
   logic [CNT_W-1:0]   cnt_value   [NUM_CNT];
   logic [CNT_W-1:0]   cnt_latched [NUM_CNT];
   logic [NUM_SRC-1:0] src_vec;
   logic [31:0]        cfg_word;
   logic [31:0]        cfg_new;
   logic [31:0]        rd_mux;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_stb  = bus_req & wb_we_i;

   // ------------------------------------------------------------
   // I/O line synchroniser and filter
   // ------------------------------------------------------------
   // a level moves only when stages two and three agree, so a single
   // sampled glitch on a pin is never counted
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         io_s1_ff   <= '0;
         io_s2_ff   <= '0;
         io_s3_ff   <= '0;
         io_filt_ff <= '0;
      end else begin
         io_s1_ff <= io_line_in;
         io_s2_ff <= io_s1_ff;
         io_s3_ff <= io_s2_ff;
         for (int i = 0; i < NUM_IO; i++) begin
            if (io_s2_ff[i] == io_s3_ff[i]) begin
               io_filt_ff[i] <= io_s3_ff[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // source vector, bit position equals source code
   // ------------------------------------------------------------
   assign src_vec = {action_in,
                     time_base_tick,
                     timer_done_pulse,
                     cnt_done,
                     io_filt_ff,
                     acq_event_in,
                     1'b0};

   // ------------------------------------------------------------
   // counter cells
   // ------------------------------------------------------------
   for (genvar n = 0; n < NUM_CNT; n++) begin : g_cnt
      cnt_ctrl_if cif ();

      assign cif.src       = src_ff[n];
      assign cif.edge_sel  = edge_ff[n];
      assign cif.term      = term_ff[n];
      assign cif.src_level = (int'(src_ff[n]) < NUM_SRC) ?
                             src_vec[src_ff[n]] : 1'b0;
      assign cif.wr_value  = wr_stb && wb_adr_i == ADDR_VALUE &&
                             index_ff == IDX_W'(n);
      assign cif.wr_data   = merge_sel(cif.value, wb_dat_i, wb_sel_i);
      assign cif.clear     = wr_stb && wb_adr_i == ADDR_CONTROL &&
                             wb_sel_i[0] && wb_dat_i[CTL_CLEAR] &&
                             index_ff == IDX_W'(n);
      assign cnt_done[n]    = cif.done;
      assign cnt_active[n]  = cif.active;
      assign cnt_value[n]   = cif.value;
      assign cnt_latched[n] = cif.latched;

      event_counter_cell u_cell (
         .clk     (clk),
         .reset_n (reset_n),
         .bus     (cif.cnt)
      );
   end

   assign count_done_event    = cnt_done;
   assign counting_indication = cnt_active;

   // ------------------------------------------------------------
   // selector and per counter configuration
   // ------------------------------------------------------------
   assign cfg_word = {22'h00_0000, edge_ff[index_ff], 3'h0,
                      src_ff[index_ff]};
   assign cfg_new  = merge_sel(cfg_word, wb_dat_i, wb_sel_i);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         index_ff <= RST_INDEX;
      end else if (wr_stb && wb_adr_i == ADDR_SELECT && wb_sel_i[0]) begin
         index_ff <= wb_dat_i[IDX_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            src_ff[i]  <= src_off;
            edge_ff[i] <= edge_up;
            term_ff[i] <= RST_TERM;
         end
      end else if (wr_stb) begin
         if (wb_adr_i == ADDR_CONFIG) begin
            src_ff[index_ff]  <= src_t'(cfg_new[CFG_SRC_LSB +: 5]);
            edge_ff[index_ff] <= edge_t'(cfg_new[CFG_EDGE_LSB +: 2]);
         end
         if (wb_adr_i == ADDR_TERM) begin
            term_ff[index_ff] <= merge_sel(term_ff[index_ff], wb_dat_i,
                                           wb_sel_i);
         end
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   // a done pulse in the same cycle as a write-one clear wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_ff <= '0;
         irq_mask_ff   <= RST_MASK;
      end else begin
         if (wr_stb && wb_adr_i == ADDR_IRQ_STATUS && wb_sel_i[0]) begin
            irq_status_ff <= (irq_status_ff & ~wb_dat_i[NUM_CNT-1:0])
                             | cnt_done;
         end else begin
            irq_status_ff <= irq_status_ff | cnt_done;
         end
         if (wr_stb && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_ff <= wb_dat_i[NUM_CNT-1:0];
         end
      end
   end

   assign irq = |(irq_status_ff & irq_mask_ff);

   // ------------------------------------------------------------
   // read mux and acknowledge
   // ------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         ADDR_SELECT:     rd_mux[IDX_W-1:0] = index_ff;
         ADDR_CONFIG:     rd_mux = cfg_word;
         ADDR_TERM:       rd_mux = term_ff[index_ff];
         ADDR_VALUE:      rd_mux = cnt_value[index_ff];
         ADDR_LATCHED:    rd_mux = cnt_latched[index_ff];
         ADDR_CONTROL:    rd_mux[CTL_ACTIVE] = cnt_active[index_ff];
         ADDR_IRQ_STATUS: rd_mux[NUM_CNT-1:0] = irq_status_ff;
         ADDR_IRQ_MASK:   rd_mux[NUM_CNT-1:0] = irq_mask_ff;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // every address answers; unmapped reads return zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_req;
         if (bus_req && !wb_we_i) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_irq_sticky;
      @(posedge clk) disable iff (!reset_n)
      cnt_done[0] |=> irq_status_ff[0];
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("done did not set sticky status");

   property p_ack_one;
      @(posedge clk) disable iff (!reset_n)
      (wb_cyc_i && wb_stb_i && !ack_ff) |=> ack_ff ##1 !ack_ff;
   endproperty
   a_ack_one: assert property (p_ack_one)
      else $error("ack not a single cycle after request");

   property p_io_filter;
      @(posedge clk) disable iff (!reset_n)
      (io_s2_ff[1] != io_s3_ff[1]) |=> io_filt_ff[1] == $past(io_filt_ff[1]);
   endproperty
   a_io_filter: assert property (p_io_filter)
      else $error("io level moved without agreeing stages");

   // a pin level takes the stage three value once the two late stages agree
   property p_io_agree;
      (io_s2_ff[1] == io_s3_ff[1]) |=> io_filt_ff[1] == $past(io_s3_ff[1]);
   endproperty
   a_io_agree: assert property (p_io_agree)
      else $error("agreed io level not taken by filter");

   property p_sel_write;
      (wr_stb && wb_adr_i == ADDR_SELECT && wb_sel_i[0])
         |=> index_ff == $past(wb_dat_i[IDX_W-1:0]);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("counter index not taken from write");

   property p_cfg_own;
      (wr_stb && wb_adr_i == ADDR_CONFIG && index_ff != 2'h1)
         |=> $stable(src_ff[1]) && $stable(edge_ff[1]);
   endproperty
   a_cfg_own: assert property (p_cfg_own)
      else $error("config write reached an unselected counter");

   property p_cfg_take;
      (wr_stb && wb_adr_i == ADDR_CONFIG && index_ff == 2'h0 && wb_sel_i[0])
         |=> src_ff[0] == src_t'($past(wb_dat_i[CFG_SRC_LSB +: 5]));
   endproperty
   a_cfg_take: assert property (p_cfg_take)
      else $error("source write missed the selected counter");

   property p_term_take;
      (wr_stb && wb_adr_i == ADDR_TERM && index_ff == 2'h1 && &wb_sel_i)
         |=> term_ff[1] == $past(wb_dat_i);
   endproperty
   a_term_take: assert property (p_term_take)
      else $error("terminal count write not taken");

   property p_irq_set;
      cnt_done[1] |=> irq_status_ff[1];
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("done of counter one did not set status");

   property p_irq_w1c;
      (wr_stb && wb_adr_i == ADDR_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[1]
          && !cnt_done[1]) |=> !irq_status_ff[1];
   endproperty
   a_irq_w1c: assert property (p_irq_w1c)
      else $error("write one did not clear status");

   property p_mask_take;
      (wr_stb && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0])
         |=> irq_mask_ff == $past(wb_dat_i[NUM_CNT-1:0]);
   endproperty
   a_mask_take: assert property (p_mask_take)
      else $error("mask write not taken");

   // ack may only follow a request, never appear on its own
   property p_ack_idle;
      !(wb_cyc_i && wb_stb_i) |=> !ack_ff;
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("ack without request");

   property p_read_value;
      (bus_req && !wb_we_i && wb_adr_i == ADDR_VALUE && index_ff == 2'h0)
         |=> wb_dat_o == $past(cnt_value[0]);
   endproperty
   a_read_value: assert property (p_read_value)
      else $error("value read returned wrong data");

   c_irq: cover property (@(posedge clk) irq);
   c_cascade: cover property (@(posedge clk)
      int'(src_ff[0]) == int'(src_cnt_end0) + 1 && cnt_done[1]);

endmodule

// File: tb/event_source_model.sv
// event source model standing in for acquisition logic, lines and timers
`timescale 1ns/1ns
module event_source_model
   import event_counter_pkg::*;
(
   input  wire logic               clk,
   output logic      [NUM_EVT-1:0] acq_event_in,
   output logic      [NUM_IO-1:0]  io_line_in,
   output logic      [NUM_TMR-1:0] timer_done_pulse,
   output logic                    time_base_tick,
   output logic      [NUM_ACT-1:0] action_in
);
   // indexed by source code minus one; cascade codes are left unused
   logic [28:0] lvl = 29'h0000_0000;

   assign acq_event_in     = lvl[11:0];
   assign io_line_in       = lvl[15:12];
   assign timer_done_pulse = lvl[23:20];
   assign time_base_tick   = lvl[24];
   assign action_in        = lvl[28:25];

   // lines are held for several cycles so the pin filter keeps each level
   task automatic pulse(input int code, input int n);
      int w;
      w = (code >= 13 && code <= 16) ? 8 : 1;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         lvl[code-1] <= 1'b1;
         repeat (w) @(posedge clk);
         lvl[code-1] <= 1'b0;
         repeat (w) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
endmodule

// File: tb/selectable_event_counter_bank_tb.sv
// self-checking bench for the event counter bank
`timescale 1ns/1ns
module selectable_event_counter_bank_tb
   import event_counter_pkg::*;
;
   // ------------------------------------------------------------
   // wiring
   // ------------------------------------------------------------
   logic               clk      = 1'b0;
   logic               reset_n  = 1'b0;
   logic               wb_cyc   = 1'b0;
   logic               wb_stb   = 1'b0;
   logic               wb_we    = 1'b0;
   logic [7:0]         wb_adr   = 8'h00;
   logic [3:0]         wb_sel   = 4'h0;
   logic [31:0]        wb_wdat  = 32'h0000_0000;
   logic [31:0]        wb_rdat;
   logic               wb_ack;
   logic [NUM_EVT-1:0] acq;
   logic [NUM_IO-1:0]  io;
   logic [NUM_TMR-1:0] tmr;
   logic               tick;
   logic [NUM_ACT-1:0] act;
   logic [NUM_CNT-1:0] done_ev;
   logic [NUM_CNT-1:0] active_ind;
   logic               irq;
   int                 n_fail   = 0;
   int                 compares = 0;
   int                 n_done   = 0;

   always #5 clk = ~clk;

   always @(posedge clk) begin
      if (done_ev[1] === 1'b1) n_done++;
   end

   event_counter_bank event_counter_bank_i (.clk(clk), .reset_n(reset_n),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .acq_event_in(acq),
      .io_line_in(io), .timer_done_pulse(tmr), .time_base_tick(tick),
      .action_in(act), .count_done_event(done_ev),
      .counting_indication(active_ind), .irq(irq));

   event_source_model src_i (.clk(clk), .acq_event_in(acq),
      .io_line_in(io), .timer_done_pulse(tmr), .time_base_tick(tick),
      .action_in(act));

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int k;
      @(posedge clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= a;
      wb_sel  <= s;
      wb_wdat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 20);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (wb_ack !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, 4'hF, q);
      check($sformatf("reg %h", a), exp, q);
   endtask

   task automatic setup(input int idx, input int c, input int e,
                        input logic [31:0] term);
      wr(ADDR_SELECT, 32'(idx));
      wr(ADDR_CONFIG, 32'((e << CFG_EDGE_LSB) | c));
      wr(ADDR_TERM, term);
      wr(ADDR_VALUE, 32'h0000_0000);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check("active", 32'h0000_000F, 32'(active_ind));
      check("irq", 32'h0000_0000, 32'(irq));
      rd(ADDR_SELECT, 32'h0000_0000);
      rd(ADDR_CONFIG, 32'h0000_0000);
      rd(ADDR_TERM, 32'h0000_0000);
      rd(ADDR_VALUE, 32'h0000_0000);
      rd(ADDR_LATCHED, 32'h0000_0000);
      rd(ADDR_IRQ_MASK, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
   endtask

   task automatic t_off();
      setup(0, 0, 0, 32'h0000_0000);
      src_i.pulse(1, 3);
      rd(ADDR_VALUE, 32'h0000_0000);
   endtask

   // every event, timer, tick and action code, three events each
   task automatic t_sources();
      for (int c = 1; c < 30; c++) begin
         if (c < 13 || c > 20) begin
            setup(0, c, 0, 32'h0000_0000);
            src_i.pulse(c, 3);
            rd(ADDR_VALUE, 32'h0000_0003);
         end
      end
   endtask

   task automatic t_edges();
      int c;
      for (int j = 0; j < 2; j++) begin
         for (int e = 0; e < 3; e++) begin
            c = (j == 0) ? 26 : 14;
            setup(0, c, e, 32'h0000_0000);
            src_i.pulse(c, 2);
            rd(ADDR_VALUE, (e == 2) ? 32'h0000_0004 : 32'h0000_0002);
         end
      end
   endtask

   // counter 1 runs to its terminal; counter 0 counts its done event
   task automatic t_term();
      setup(0, 18, 0, 32'h0000_0000);
      setup(1, 25, 0, 32'h0000_0003);
      wr(ADDR_IRQ_MASK, 32'h0000_0002);
      src_i.pulse(25, 3);
      check("active", 32'h0000_000D, 32'(active_ind));
      check("irq", 32'h0000_0001, 32'(irq));
      rd(ADDR_IRQ_STATUS, 32'h0000_0002);
      rd(ADDR_CONTROL, 32'h0000_0000);
      src_i.pulse(25, 2);
      rd(ADDR_VALUE, 32'h0000_0003);
      check("done pulses", 32'h0000_0001, 32'(n_done));
      wr(ADDR_IRQ_STATUS, 32'h0000_0002);
      check("irq", 32'h0000_0000, 32'(irq));
      wr(ADDR_SELECT, 32'h0000_0000);
      rd(ADDR_VALUE, 32'h0000_0001);
   endtask

   task automatic t_clear();
      logic [31:0] q;
      wr(ADDR_SELECT, 32'h0000_0001);
      wr(ADDR_CONTROL, 32'h0000_0001);
      rd(ADDR_LATCHED, 32'h0000_0003);
      rd(ADDR_VALUE, 32'h0000_0000);
      rd(ADDR_CONTROL, 32'h0000_0001);
      check("active", 32'h0000_000F, 32'(active_ind));
      src_i.pulse(25, 2);
      rd(ADDR_VALUE, 32'h0000_0002);
      wr(ADDR_VALUE, 32'h0000_0100);
      src_i.pulse(25, 1);
      rd(ADDR_VALUE, 32'h0000_0101);
      wb(1'b1, ADDR_VALUE, 32'hAABB_CCDD, 4'h1, q);
      rd(ADDR_VALUE, 32'h0000_01DD);
      wr(ADDR_LATCHED, 32'h0000_0005);
      rd(ADDR_LATCHED, 32'h0000_0003);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_off();
      t_sources();
      t_edges();
      t_term();
      t_clear();
      print_verdict();
   end
endmodule
